// [rtl/mpg_top.v]
// How it works
// R1 - Up to eight modulator channels, each with private state and settings.
// R2 - Per-channel style: 0 single, 1 output plus direction, 2 up/down.
// R3 - One fast tick and one slow update step every channel together.
// R4 - Command times scale gives requested duty before limiting.
// R5 - Enable low forces duty zero and all outputs inactive.
// R6 - Carrier setting zero selects pulse-density modulation.
// R7 - Carrier beyond internal limit is overwritten with the limit.
// R8 - Dither off: carrier period snapped to nearest whole tick count.
// R9 - Dither on: fractional period and high time averaged over cycles.
// R10 - Dither off: period and duty rounded to whole ticks.
// R11 - Enabled nonzero duty below floor is raised to floor; the code raises zero duty to floor too.
// R12 - Duty clamped to the ceiling setting.
// R13 - Read-only effective duty after scaling, limiting and rounding.
// R14 - Style 0: one output, negative commands count as zero.
// R15 - Style 1: duty from command magnitude.
// R16 - Style 1: direction low for positive, high for negative.
// R17 - Style 2: positive command drives up, down stays low.
// R18 - Style 2: negative command drives down, up stays low.
// R19 - Tick period sets top carrier rate and duty resolution.
// R20 - Scaling and limits in slow step; fast tick integer only.
// R21 - Width mode: count ticks per period, high for high-time count.
// R22 - Density mode: add duty each tick, pulse on overflow.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "mpg_map.vh"
module mpg_top #(
  parameter NCH = 8
) (
  input  wire           CLOCK_I,
  input  wire           RST_I,
  input  wire           CE_I,
  input  wire [8:0]     S_AXI_AWADDR_I,
  input  wire           S_AXI_AWVALID_I,
  output wire           S_AXI_AWREADY_O,
  input  wire [31:0]    S_AXI_WDATA_I,
  input  wire [3:0]     S_AXI_WSTRB_I,
  input  wire           S_AXI_WVALID_I,
  output wire           S_AXI_WREADY_O,
  output wire [1:0]     S_AXI_BRESP_O,
  output wire           S_AXI_BVALID_O,
  input  wire           S_AXI_BREADY_I,
  input  wire [8:0]     S_AXI_ARADDR_I,
  input  wire           S_AXI_ARVALID_I,
  output wire           S_AXI_ARREADY_O,
  output wire [31:0]    S_AXI_RDATA_O,
  output wire [1:0]     S_AXI_RRESP_O,
  output wire           S_AXI_RVALID_O,
  input  wire           S_AXI_RREADY_I,
  output wire [NCH-1:0] PWM_O,
  output wire [NCH-1:0] DIR_O,
  output wire [NCH-1:0] UP_O,
  output wire [NCH-1:0] DOWN_O
);

  reg        awready_reg;
  reg        wready_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  reg        arready_reg;
  reg        rvalid_reg;
  reg [1:0]  rresp_reg;
  reg [31:0] rdata_reg;
  reg [15:0] tick_div_reg;
  reg [15:0] upd_div_reg;
  reg [15:0] tick_cnt_reg;
  reg [15:0] upd_cnt_reg;
  reg        tick_reg;
  reg        upd_reg;

  wire        wr_go;
  wire        rd_go;
  wire [31:0] wd;
  wire [3:0]  wa_ch;
  wire [2:0]  wa_idx;
  wire [3:0]  ra_ch;
  wire [2:0]  ra_idx;

  // Both halves of a write are taken in one beat, so order never matters
  assign wr_go  = CE_I & S_AXI_AWVALID_I & S_AXI_WVALID_I & ~awready_reg
                  & ~bvalid_reg;
  assign rd_go  = CE_I & S_AXI_ARVALID_I & ~arready_reg & ~rvalid_reg;
  assign wd     = S_AXI_WDATA_I;
  assign wa_ch  = S_AXI_AWADDR_I[8:`MPG_CH_SHIFT];
  assign wa_idx = S_AXI_AWADDR_I[4:2];
  assign ra_ch  = S_AXI_ARADDR_I[8:`MPG_CH_SHIFT];
  assign ra_idx = S_AXI_ARADDR_I[4:2];

  assign S_AXI_AWREADY_O = awready_reg;
  assign S_AXI_WREADY_O  = wready_reg;
  assign S_AXI_BVALID_O  = bvalid_reg;
  assign S_AXI_BRESP_O   = bresp_reg;
  assign S_AXI_ARREADY_O = arready_reg;
  assign S_AXI_RVALID_O  = rvalid_reg;
  assign S_AXI_RRESP_O   = rresp_reg;
  assign S_AXI_RDATA_O   = rdata_reg;

  // Per-channel readback and hit flags, filled by the generate loop
  wire [32*NCH-1:0] ch_rdata;
  wire [NCH-1:0]    ch_wmap;
  wire [NCH-1:0]    ch_rmap;

  wire glob_wmap = (S_AXI_AWADDR_I == `MPG_TICK_DIV_OFS)
                 | (S_AXI_AWADDR_I == `MPG_UPD_DIV_OFS);

  // Single tick and update strobes shared by every channel
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      tick_div_reg <= `MPG_TICK_DIV_RST;
      upd_div_reg  <= `MPG_UPD_DIV_RST;
      tick_cnt_reg <= 16'h0000;
      upd_cnt_reg  <= 16'h0000;
      tick_reg     <= 1'b0;
      upd_reg      <= 1'b0;
    end else if (CE_I) begin
      tick_reg <= 1'b0;
      upd_reg  <= 1'b0;
      if (tick_cnt_reg >= tick_div_reg) begin // R19
        tick_cnt_reg <= 16'h0000;
        tick_reg     <= 1'b1; // R3
        if (upd_cnt_reg >= upd_div_reg) begin
          upd_cnt_reg <= 16'h0000;
          upd_reg     <= 1'b1; // R3
        end else begin
          upd_cnt_reg <= upd_cnt_reg + 16'h0001;
        end
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      end
      if (wr_go && S_AXI_AWADDR_I == `MPG_TICK_DIV_OFS) begin
        if (S_AXI_WSTRB_I[0]) tick_div_reg[7:0]  <= wd[7:0];
        if (S_AXI_WSTRB_I[1]) tick_div_reg[15:8] <= wd[15:8];
      end
      if (wr_go && S_AXI_AWADDR_I == `MPG_UPD_DIV_OFS) begin
        if (S_AXI_WSTRB_I[0]) upd_div_reg[7:0]  <= wd[7:0];
        if (S_AXI_WSTRB_I[1]) upd_div_reg[15:8] <= wd[15:8];
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_ch // R1
      localparam [3:0] CH_SEL = ch + 1;
      reg [15:0] value_reg;
      reg [15:0] scale_reg;
      reg [23:0] period_reg;
      reg        en_cfg_reg;
      reg        dith_reg;
      reg [1:0]  style_reg;
      reg [15:0] floor_reg;
      reg [15:0] ceil_reg;
      reg [15:0] duty_reg;
      reg [15:0] effect_reg;
      reg [23:0] high_reg;
      reg        neg_reg;
      reg        en_reg;
      reg [23:0] cnt_reg;
      reg [15:0] acc_reg;
      reg        pwm_reg;
      reg        dir_reg;
      reg        up_reg;
      reg        down_reg;

      wire wsel = wr_go && (wa_ch == CH_SEL);
      wire hsel = wa_ch == CH_SEL;
      assign ch_wmap[ch] = hsel && (wa_idx <= `MPG_CEIL_IDX);
      assign ch_rmap[ch] = (ra_ch == CH_SEL)
                           && (ra_idx <= `MPG_EFFECT_IDX);

      // Slow path: magnitude, scale, limits
      wire        neg = value_reg[15];
      wire [15:0] neg_mag = 16'h0000 - value_reg;
      wire [15:0] mag = !neg ? value_reg :
                        (style_reg == `MPG_STYLE_SINGLE) ? 16'h0000 // R14
                        : neg_mag; // R15
      wire [31:0] prod = mag * scale_reg; // R4
      wire [15:0] req  = (|prod[31:24]) ? 16'hffff : prod[23:8];
      wire [15:0] capd = (req > ceil_reg) ? ceil_reg : req; // R12
      // Zero is raised too, so a clipped negative command still sees floor
      wire [15:0] flrd = (capd < floor_reg)
                         ? floor_reg : capd; // R11
      wire [15:0] lim  = en_cfg_reg ? flrd : 16'h0000; // R5

      wire [39:0] hprod = lim * period_reg;
      wire [24:0] hrnd  = {1'b0, hprod[39:16]} + 25'h0000080;
      wire [23:0] hwhole = hrnd[24] ? 24'hffff00
                           : {hrnd[23:8], 8'h00};
      wire [23:0] hnext = dith_reg ? hprod[39:16] : hwhole; // R10
      // Effective duty: the limited duty, or zero when a nonzero period rounds the high time to zero
      wire [15:0] eff_rnd = (period_reg == 24'h000000) ? lim
                            : (hwhole == 24'h000000) ? 16'h0000
                            : lim;

      wire [24:0] prnd = {1'b0, period_reg} + 25'h0000080;

      always @(posedge CLOCK_I) begin
        if (RST_I) begin
          value_reg  <= 16'h0000;
          scale_reg  <= `MPG_SCALE_RST;
          period_reg <= `MPG_PERIOD_RST;
          en_cfg_reg <= 1'b0;
          dith_reg   <= 1'b0;
          style_reg  <= `MPG_STYLE_SINGLE;
          floor_reg  <= `MPG_FLOOR_RST;
          ceil_reg   <= `MPG_CEIL_RST;
          duty_reg   <= 16'h0000;
          effect_reg <= 16'h0000;
          high_reg   <= 24'h000000;
          neg_reg    <= 1'b0;
          en_reg     <= 1'b0;
        end else if (CE_I) begin
          if (upd_reg) begin // R20
            duty_reg   <= lim;
            effect_reg <= dith_reg ? lim : eff_rnd; // R13
            high_reg   <= hnext;
            neg_reg    <= neg;
            en_reg     <= en_cfg_reg;
            if (period_reg != 24'h000000 &&
                period_reg < `MPG_PERIOD_MIN) begin
              period_reg <= `MPG_PERIOD_MIN; // R7
            end else if (period_reg != 24'h000000 && !dith_reg) begin
              period_reg <= prnd[24] ? 24'hffff00
                            : {prnd[23:8], 8'h00}; // R8
            end
          end
          // Software write wins over the settle of the same cycle
          if (wsel) begin
            case (wa_idx)
              `MPG_VALUE_IDX:  value_reg  <= wd[15:0];
              `MPG_SCALE_IDX:  scale_reg  <= wd[15:0];
              `MPG_PERIOD_IDX: period_reg <= wd[23:0];
              `MPG_CONFIG_IDX: begin
                en_cfg_reg <= wd[`MPG_CFG_EN_BIT];
                dith_reg   <= wd[`MPG_CFG_DITH_BIT];
                // Code 3 is illegal and falls back to single output
                style_reg  <= (wd[5:4] == 2'h3) ? `MPG_STYLE_SINGLE
                              : wd[`MPG_CFG_STYLE_MSB:`MPG_CFG_STYLE_LSB];
              end
              `MPG_FLOOR_IDX:  floor_reg  <= wd[15:0]; // R11
              `MPG_CEIL_IDX:   ceil_reg   <= wd[15:0]; // R12
              default: begin
              end
            endcase
          end
        end
      end

      // Fast path: integer counting only
      wire [24:0] cstep = {1'b0, cnt_reg} + `MPG_ONE_TICK;
      wire [24:0] cwrap = cstep - {1'b0, period_reg};
      wire        density_modulation   = period_reg == 24'h000000; // R6
      wire [16:0] asum  = {1'b0, acc_reg} + {1'b0, duty_reg};
      wire        mod   = density_modulation ? asum[16] // R22
                          : (cnt_reg < high_reg); // R21

      always @(posedge CLOCK_I) begin
        if (RST_I) begin
          cnt_reg  <= 24'h000000;
          acc_reg  <= 16'h0000;
          pwm_reg  <= 1'b0;
          dir_reg  <= 1'b0;
          up_reg   <= 1'b0;
          down_reg <= 1'b0;
        end else if (CE_I && tick_reg) begin // R3
          // Leftover fraction carries over, which is the dither
          // A shortened period restarts the count instead of draining it
          cnt_reg <= (cnt_reg >= period_reg) ? 24'h000000
                     : (cstep >= {1'b0, period_reg}) ? cwrap[23:0]
                     : cstep[23:0]; // R9
          acc_reg <= asum[15:0]; // R22
          pwm_reg  <= en_reg && mod
                      && (style_reg != `MPG_STYLE_UPDN); // R5
          dir_reg  <= en_reg && neg_reg
                      && (style_reg == `MPG_STYLE_DIR); // R16
          up_reg   <= en_reg && mod && !neg_reg
                      && (style_reg == `MPG_STYLE_UPDN); // R17
          down_reg <= en_reg && mod && neg_reg
                      && (style_reg == `MPG_STYLE_UPDN); // R18
        end
      end

      assign PWM_O[ch]  = pwm_reg; // R2
      assign DIR_O[ch]  = dir_reg;
      assign UP_O[ch]   = up_reg;
      assign DOWN_O[ch] = down_reg;

      reg [31:0] rd_word;
      always @* begin
        rd_word = 32'h00000000;
        case (ra_idx)
          `MPG_VALUE_IDX:  rd_word = {16'h0000, value_reg};
          `MPG_SCALE_IDX:  rd_word = {16'h0000, scale_reg};
          `MPG_PERIOD_IDX: rd_word = {8'h00, period_reg};
          `MPG_CONFIG_IDX: rd_word = {26'h0000000, style_reg, 2'h0,
                                      dith_reg, en_cfg_reg};
          `MPG_FLOOR_IDX:  rd_word = {16'h0000, floor_reg};
          `MPG_CEIL_IDX:   rd_word = {16'h0000, ceil_reg};
          `MPG_EFFECT_IDX: rd_word = {16'h0000, effect_reg}; // R13
          default:         rd_word = 32'h00000000;
        endcase
      end
      assign ch_rdata[32*ch +: 32] = (ra_ch == CH_SEL) ? rd_word
                                     : 32'h00000000;
    end
  endgenerate

  // Read data OR-reduced over channels
  reg [31:0] ch_or;
  integer    k;
  always @* begin
    ch_or = 32'h00000000;
    for (k = 0; k < NCH; k = k + 1) begin
      ch_or = ch_or | ch_rdata[32*k +: 32];
    end
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `MPG_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `MPG_RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else if (CE_I) begin
      awready_reg <= wr_go;
      wready_reg  <= wr_go;
      arready_reg <= rd_go;
      if (wr_go) begin
        bresp_reg  <= (glob_wmap || (|ch_wmap)) ? `MPG_RESP_OKAY
                      : `MPG_RESP_SLVERR;
      end
      // Response only after the address and data handshake edge
      if (awready_reg) begin
        bvalid_reg <= 1'b1;
      end else if (S_AXI_BREADY_I) begin
        bvalid_reg <= 1'b0;
      end
      if (rd_go) begin
        if (S_AXI_ARADDR_I == `MPG_TICK_DIV_OFS) begin
          rdata_reg <= {16'h0000, tick_div_reg};
          rresp_reg <= `MPG_RESP_OKAY;
        end else if (S_AXI_ARADDR_I == `MPG_UPD_DIV_OFS) begin
          rdata_reg <= {16'h0000, upd_div_reg};
          rresp_reg <= `MPG_RESP_OKAY;
        end else if (|ch_rmap) begin
          rdata_reg <= ch_or;
          rresp_reg <= `MPG_RESP_OKAY;
        end else begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `MPG_RESP_SLVERR;
        end
      end
      if (arready_reg) begin
        rvalid_reg <= 1'b1;
      end else if (S_AXI_RREADY_I) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

endmodule

// [rtl/mpg_map.vh]
`ifndef MPG_MAP_VH
`define MPG_MAP_VH
// Global registers
`define MPG_TICK_DIV_OFS   9'h000
`define MPG_UPD_DIV_OFS    9'h004
`define MPG_TICK_DIV_RST   16'h04e1
`define MPG_UPD_DIV_RST    16'h0064
// Channel n sits at (n+1) * 0x20
`define MPG_CH_SHIFT       5
`define MPG_VALUE_IDX      3'h0
`define MPG_SCALE_IDX      3'h1
`define MPG_PERIOD_IDX     3'h2
`define MPG_CONFIG_IDX     3'h3
`define MPG_FLOOR_IDX      3'h4
`define MPG_CEIL_IDX       3'h5
`define MPG_EFFECT_IDX     3'h6
// Config fields
`define MPG_CFG_EN_BIT     0
`define MPG_CFG_DITH_BIT   1
`define MPG_CFG_STYLE_LSB  4
`define MPG_CFG_STYLE_MSB  5
// Output styles
`define MPG_STYLE_SINGLE   2'h0
`define MPG_STYLE_DIR      2'h1
`define MPG_STYLE_UPDN     2'h2
// Reset values
`define MPG_SCALE_RST      16'h0100
`define MPG_PERIOD_RST     24'h000000
`define MPG_FLOOR_RST      16'h0000
`define MPG_CEIL_RST       16'hffff
// Shortest carrier period, 2.0 ticks in 16.8 form
`define MPG_PERIOD_MIN     24'h000200
`define MPG_ONE_TICK       25'h0000100
`define MPG_RESP_OKAY      2'h0
`define MPG_RESP_SLVERR    2'h2
`endif

// [testbench/mpg_stage.sv]
`timescale 1ns/10ps
module mpg_stage (
  input  wire clk_i,
  input  wire up_i,
  input  wire down_i,
  output reg  short_o
);
  // Both bridge legs on together would short the supply rail
  initial short_o = 1'b0;
  always @(posedge clk_i) begin
    if (up_i && down_i)
      short_o <= 1'b1;
  end
endmodule

// [testbench/mpg_top_sva.sv]
`timescale 1ns/10ps
module mpg_top_sva #(
  parameter NCH = 8
) (
  input wire           CLOCK_I,
  input wire           RST_I,
  input wire           CE_I,
  input wire           S_AXI_AWREADY_O,
  input wire           S_AXI_WREADY_O,
  input wire           S_AXI_BVALID_O,
  input wire           S_AXI_BREADY_I,
  input wire           S_AXI_ARREADY_O,
  input wire [31:0]    S_AXI_RDATA_O,
  input wire           S_AXI_RVALID_O,
  input wire           S_AXI_RREADY_I,
  input wire [NCH-1:0] PWM_O,
  input wire [NCH-1:0] DIR_O,
  input wire [NCH-1:0] UP_O,
  input wire [NCH-1:0] DOWN_O
);
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RST_I);
  sequence s_wr_ans;
    S_AXI_AWREADY_O && S_AXI_WREADY_O
      ##1 S_AXI_BVALID_O && !S_AXI_AWREADY_O;
  endsequence
  sequence s_rd_ans;
    S_AXI_ARREADY_O ##1 S_AXI_RVALID_O && !S_AXI_ARREADY_O;
  endsequence
  a_write_pair: assert property ((S_AXI_AWREADY_O || S_AXI_WREADY_O) && CE_I
    |-> s_wr_ans) else $error("write answer split");
  a_read_pulse: assert property (S_AXI_ARREADY_O && CE_I
    |-> s_rd_ans) else $error("read ready not a pulse");
  a_b_after_aw: assert property ($rose(S_AXI_BVALID_O)
    |-> $past(S_AXI_AWREADY_O)) else $error("bvalid before handshake");
  a_r_after_ar: assert property ($rose(S_AXI_RVALID_O)
    |-> $past(S_AXI_ARREADY_O)) else $error("rvalid before handshake");
  a_b_hold: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I
    |=> S_AXI_BVALID_O) else $error("bvalid dropped early");
  a_r_hold: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I
    |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O)) else $error("rdata moved");
  a_b_once: assert property (S_AXI_BVALID_O && S_AXI_BREADY_I && CE_I
    |=> !S_AXI_BVALID_O) else $error("bvalid repeated");
  a_r_once: assert property (S_AXI_RVALID_O && S_AXI_RREADY_I && CE_I
    |=> !S_AXI_RVALID_O) else $error("rvalid repeated");
  a_legs_apart: assert property (!(|(UP_O & DOWN_O)))
    else $error("up and down both high");
  a_ce_freeze: assert property (!CE_I
    |=> $stable({PWM_O, DIR_O, UP_O, DOWN_O})) else $error("moved while frozen");
  a_reset_idle: assert property (disable iff (1'b0) RST_I && CE_I
    |=> !{PWM_O, DIR_O, UP_O, DOWN_O} && !S_AXI_BVALID_O && !S_AXI_RVALID_O)
    else $error("outputs active after reset");
endmodule
bind mpg_top mpg_top_sva #(.NCH(NCH)) mpg_top_sva_i (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WREADY_O(S_AXI_WREADY_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
  .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
  .PWM_O(PWM_O), .DIR_O(DIR_O), .UP_O(UP_O), .DOWN_O(DOWN_O)
);

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`include "mpg_map.vh"
module tb_top;
  localparam NCH = 2;
  localparam OK  = `MPG_RESP_OKAY;
  reg            clk, rst, ce, awvalid, wvalid, bready, arvalid, rready;
  reg  [8:0]     awaddr, araddr;
  reg  [31:0]    wdata;
  wire           awready, wready, bvalid, arready, rvalid, short;
  wire [1:0]     bresp, rresp;
  wire [31:0]    rdata;
  wire [NCH-1:0] pwm, dir, up, down;
  reg  [33:0]    exp_q[$];
  reg  [33:0]    e;
  integer        mismatches, check_count, seed, k, n_p, n_d, n_u, n_n, n_q;
  mpg_top #(.NCH(NCH)) mpg_top_i (.CLOCK_I(clk), .RST_I(rst), .CE_I(ce),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
    .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .PWM_O(pwm),
    .DIR_O(dir), .UP_O(up), .DOWN_O(down));
  mpg_stage mpg_stage_i (.clk_i(clk), .up_i(up[0]), .down_i(down[0]),
    .short_o(short));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task final_report;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Counts over a window: allow a few clocks of phase slack; -1 skips
  task near(input integer got, input integer exp);
    begin
      if (exp >= 0)
        chk((got >= exp - 6 && got <= exp + 6) ? exp : got, exp);
    end
  endtask
  always @(posedge clk) begin
    if (bvalid && bready) begin
      e = exp_q.pop_front();
      chk({30'h0, bresp}, {30'h0, e[33:32]});
    end
    if (rvalid && rready) begin
      e = exp_q.pop_front();
      chk(rdata, e[31:0]);
      chk({30'h0, rresp}, {30'h0, e[33:32]});
    end
  end
  task wr(input [8:0] a, input [31:0] d, input [1:0] r);
    reg b;
    begin
      exp_q.push_back({r, 32'h0});
      b = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b) begin
        @(posedge clk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
        b = bvalid;
      end
      bready <= 1'b0;
    end
  endtask
  task rd(input [8:0] a, input [31:0] d, input [1:0] r);
    reg g;
    begin
      exp_q.push_back({r, d});
      g = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!g) begin
        @(posedge clk);
        if (arready)
          arvalid <= 1'b0;
        g = rvalid;
      end
      rready <= 1'b0;
    end
  endtask
  function [8:0] ad(input integer ch, input [2:0] idx);
    ad = ((ch + 1) << `MPG_CH_SHIFT) | (idx << 2);
  endfunction
  // Same settings on every channel, then let a slow update land
  task setch(input [15:0] v, input [15:0] s, input [23:0] p,
             input [5:0] c, input [15:0] f, input [15:0] l);
    integer ch;
    begin
      for (ch = 0; ch < NCH; ch = ch + 1) begin
        // Dither first, so a snap cannot hit the new period early
        wr(ad(ch, `MPG_CONFIG_IDX), {26'h0, c}, OK);
        wr(ad(ch, `MPG_VALUE_IDX), {16'h0, v}, OK);
        wr(ad(ch, `MPG_SCALE_IDX), {16'h0, s}, OK);
        wr(ad(ch, `MPG_PERIOD_IDX), {8'h0, p}, OK);
        wr(ad(ch, `MPG_FLOOR_IDX), {16'h0, f}, OK);
        wr(ad(ch, `MPG_CEIL_IDX), {16'h0, l}, OK);
      end
      repeat (30) @(posedge clk);
    end
  endtask
  task out(input [5:0] c, input [15:0] v, input [23:0] p, input integer ep,
           input integer ed, input integer eu, input integer en);
    begin
      setch(v, 16'h0100, p, c, (c[0] ? 16'h0 : 16'h2000), 16'hffff);
      {n_p, n_d, n_u, n_n, n_q} = 0;
      repeat (400) begin
        @(posedge clk);
        n_p = n_p + pwm[0];
        n_q = n_q + pwm[1];
        n_d = n_d + dir[0];
        n_u = n_u + up[0];
        n_n = n_n + down[0];
      end
      near(n_p, ep);
      near(n_d, ed);
      near(n_u, eu);
      near(n_n, en);
      near(n_q, ep);
      $display("output case style %0d done", c[5:4]);
    end
  endtask
  initial begin
    seed = 32'h566e1a41;
    {mismatches, check_count} = 0;
    {rst, ce} = 2'b11;
    {awvalid, wvalid, bready, arvalid, rready} = 0;
    {awaddr, araddr, wdata} = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(`MPG_TICK_DIV_OFS, {16'h0, `MPG_TICK_DIV_RST}, OK);
    rd(`MPG_UPD_DIV_OFS, {16'h0, `MPG_UPD_DIV_RST}, OK);
    rd(ad(1, `MPG_SCALE_IDX), {16'h0, `MPG_SCALE_RST}, OK);
    rd(ad(0, `MPG_PERIOD_IDX), {8'h0, `MPG_PERIOD_RST}, OK);
    rd(ad(0, `MPG_CONFIG_IDX), 32'h0, OK);
    rd(ad(0, `MPG_CEIL_IDX), {16'h0, `MPG_CEIL_RST}, OK);
    rd(ad(0, `MPG_EFFECT_IDX), 32'h0, OK);
    rd(9'h1fc, 32'h0, `MPG_RESP_SLVERR);
    wr(9'h1fc, 32'h1234, `MPG_RESP_SLVERR);
    $display("reset and map test done");
    // Short tick and update spans keep the run brief
    wr(`MPG_TICK_DIV_OFS, 32'h1, OK);
    wr(`MPG_UPD_DIV_OFS, 32'h2, OK);
    repeat (3) begin
      k = $random(seed);
      wr(ad(0, `MPG_FLOOR_IDX), k, OK);
      rd(ad(0, `MPG_FLOOR_IDX), k & 32'hffff, OK);
    end
    setch(16'h1000, 16'h0100, 24'h000100, 6'h01, 16'h0, 16'hffff);
    rd(ad(0, `MPG_PERIOD_IDX), 32'h200, OK);
    setch(16'h1000, 16'h0100, 24'h000380, 6'h01, 16'h0, 16'hffff);
    rd(ad(0, `MPG_PERIOD_IDX), 32'h400, OK);
    setch(16'h1000, 16'h0100, 24'h000380, 6'h03, 16'h0, 16'hffff);
    rd(ad(0, `MPG_PERIOD_IDX), 32'h380, OK);
    setch(16'h2000, 16'h0200, 24'h0, 6'h01, 16'h0, 16'hffff);
    rd(ad(0, `MPG_EFFECT_IDX), 32'h4000, OK);
    setch(16'h2000, 16'h0200, 24'h0, 6'h01, 16'h0, 16'h1000);
    rd(ad(0, `MPG_EFFECT_IDX), 32'h1000, OK);
    setch(16'h0010, 16'h0100, 24'h0, 6'h01, 16'h2000, 16'hffff);
    rd(ad(1, `MPG_EFFECT_IDX), 32'h2000, OK);
    setch(16'hc000, 16'h0100, 24'h0, 6'h01, 16'h2000, 16'hffff);
    rd(ad(0, `MPG_EFFECT_IDX), 32'h2000, OK);
    setch(16'h0100, 16'h0100, 24'h000400, 6'h01, 16'h0, 16'hffff);
    rd(ad(0, `MPG_EFFECT_IDX), 32'h0, OK);
    setch(16'h0100, 16'h0100, 24'h000400, 6'h03, 16'h0, 16'hffff);
    rd(ad(0, `MPG_EFFECT_IDX), 32'h100, OK);
    setch(16'h0010, 16'h0100, 24'h0, 6'h00, 16'h2000, 16'hffff);
    rd(ad(0, `MPG_EFFECT_IDX), 32'h0, OK);
    $display("duty limit test done");
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    out(6'h01, 16'h4000, 24'h0, 100, -1, -1, -1);
    out(6'h01, 16'h4000, 24'h400, 100, -1, -1, -1);
    out(6'h01, 16'hc000, 24'h0, 0, -1, -1, -1);
    out(6'h11, 16'hc000, 24'h0, 100, 400, -1, -1);
    out(6'h11, 16'h4000, 24'h400, 100, 0, -1, -1);
    out(6'h21, 16'h4000, 24'h0, -1, -1, 100, 0);
    out(6'h21, 16'hc000, 24'h400, -1, -1, 0, 100);
    out(6'h20, 16'h4000, 24'h0, 0, 0, 0, 0);
    chk({31'h0, short}, 32'h0);
    final_report;
  end
  initial begin
    #(8 * 40000);
    mismatches = mismatches + 1;
    final_report;
  end
endmodule
